/* File: src/iopit_cfg.svh */
// constants for the io port and interval timer block
`ifndef IOPIT_CFG_SVH
`define IOPIT_CFG_SVH
`define IOPIT_ADDR_CTRL 5'h00
`define IOPIT_ADDR_CLK_INT 5'h03
`define IOPIT_ADDR_TOP_INT 5'h0f
`define IOPIT_PORT_BASE_BIT 4
`define IOPIT_TIMER_WIDTH 14
`define IOPIT_PRESCALE 64
`define IOPIT_CODE_RESET 4'h0
`define IOPIT_CODE_NONE 4'hf
`define IOPIT_SHARED_MSB_PORT 15
`define IOPIT_SHARED_LSB_PORT 7
`endif

/* File: src/iopit_pkg.sv */
// types for the io port and interval timer block
package iopit_pkg;
   typedef enum logic [1:0] {
      IOPIT_CODE_HOLD_RESET,
      IOPIT_CODE_RUN
   } iopit_code_state_t;
endpackage

/* File: src/iopit_prescaler.sv */
// divide-by-n enable pulse for the timer
`timescale 1ns/1ps
`default_nettype none
module iopit_prescaler #(
   parameter int DIVIDE = 64
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic restart,
   output logic tick
);
   localparam int W = $clog2(DIVIDE);
   localparam logic [W-1:0] LAST = W'(DIVIDE - 1);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   always_comb begin
      if (restart || cnt_q == LAST) begin
         cnt_d = '0;
      end else begin
         cnt_d = cnt_q + W'(1);
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
   assign tick = (cnt_q == LAST) && !restart;
endmodule // iopit_prescaler
`default_nettype wire

/* File: src/iopit_prio_enc.sv */
// priority encoder for fifteen interrupt lines
`timescale 1ns/1ps
`default_nettype none
`include "iopit_cfg.svh"
module iopit_prio_enc (
   input wire logic [15:1] active,
   output logic any,
   output logic [3:0] code
);
   always_comb begin
      any = 1'b0;
      code = `IOPIT_CODE_NONE;
      for (int i = 15; i >= 1; i--) begin
         if (active[i]) begin
            any = 1'b1;
            code = 4'(i);
         end
      end
   end
endmodule // iopit_prio_enc
`default_nettype wire

/* File: src/iopit_top.sv */
// io port section and interval timer on a bit-addressed register port
`timescale 1ns/1ps
`default_nettype none
`include "iopit_cfg.svh"
module iopit_top #(
   parameter int TIMER_WIDTH = `IOPIT_TIMER_WIDTH,
   parameter int PRESCALE = `IOPIT_PRESCALE
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic power_up_reset_n,
   input wire logic [4:0] bus_addr,
   input wire logic bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic bus_rdata,
   input wire logic [6:1] int_pin_n,
   input wire logic [15:0] port_in,
   output logic [15:0] port_out,
   output logic [15:0] port_oe,
   output logic interrupt_request_n,
   output logic [3:0] interrupt_code_lines
);
   localparam int TW = TIMER_WIDTH;
   // pins 7..15 shared with ports 15..7
   logic [15:1] int_level_n;
   genvar g;
   for (g = 1; g <= 15; g++) begin : g_map
      if (g <= 6) begin : g_ded
         assign int_level_n[g] = int_pin_n[g];
      end else begin : g_sh
         assign int_level_n[g] = port_in[`IOPIT_SHARED_MSB_PORT + `IOPIT_SHARED_LSB_PORT - g];
      end
   end

   logic rst_any;
   assign rst_any = sys_rst || !power_up_reset_n;

   function automatic logic is_port(input logic [4:0] a);
      return a[`IOPIT_PORT_BASE_BIT];
   endfunction

   // control, masks, ports
   logic mode_q, mode_d;
   logic [15:1] mask_q, mask_d;
   logic [15:0] pout_q, pout_d, poe_q, poe_d;
   logic [TW-1:0] start_q, start_d, cnt_q, cnt_d, cap_q, cap_d;
   logic clk_int_q, clk_int_d;
   logic restart;
   logic tick;
   logic timer_en;
   logic wr_port, wr_low;
   logic [3:0] idx;

   assign wr_port = bus_wr && is_port(bus_addr);
   assign wr_low = bus_wr && !is_port(bus_addr);
   assign idx = bus_addr[3:0];
   assign timer_en = (start_q != '0);

   always_comb begin
      mode_d = mode_q;
      mask_d = mask_q;
      pout_d = pout_q;
      poe_d = poe_q;
      start_d = start_q;
      restart = 1'b0;
      if (wr_port) begin
         pout_d[idx] = bus_wdata;
         poe_d[idx] = 1'b1;
      end
      if (wr_low) begin
         if (bus_addr == `IOPIT_ADDR_CTRL) begin
            mode_d = bus_wdata;
         end else if (!mode_q) begin
            mask_d[idx] = bus_wdata;
         end else if (bus_addr == `IOPIT_ADDR_TOP_INT) begin
            if (bus_wdata) begin
               poe_d = '0;
            end
         end else if (32'(idx) <= TW) begin
            start_d[idx - 4'(1)] = bus_wdata;
            restart = 1'b1;
         end
      end
   end

   iopit_prescaler #(.DIVIDE(PRESCALE)) u_pre (
      .clk(clk),
      .sys_rst(rst_any),
      .restart(restart),
      .tick(tick)
   );

   logic clear_int;
   assign clear_int = wr_low && bus_addr == `IOPIT_ADDR_CLK_INT;
   logic soft_rst;
   assign soft_rst = wr_low && mode_q && bus_addr == `IOPIT_ADDR_TOP_INT && bus_wdata;

   always_comb begin
      cnt_d = cnt_q;
      clk_int_d = clk_int_q;
      cap_d = cap_q;
      if (clear_int || !timer_en) begin
         clk_int_d = 1'b0;
      end
      if (restart) begin
         cnt_d = start_d;
      end else if (timer_en && tick) begin
         if (cnt_q <= TW'(1)) begin
            cnt_d = start_q;
            clk_int_d = 1'b1;
         end else begin
            cnt_d = cnt_q - TW'(1);
         end
      end
      if (wr_low && bus_addr == `IOPIT_ADDR_CTRL && bus_wdata) begin
         cap_d = cnt_q;
      end
   end

   always_ff @(posedge clk) begin
      if (rst_any) begin
         mode_q <= 1'b0;
         mask_q <= '0;
         pout_q <= '0;
         poe_q <= '0;
         start_q <= '0;
         cnt_q <= '0;
         cap_q <= '0;
         clk_int_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         mask_q <= mask_d;
         pout_q <= pout_d;
         poe_q <= poe_d;
         start_q <= start_d;
         cnt_q <= cnt_d;
         cap_q <= cap_d;
         clk_int_q <= clk_int_d;
      end
   end

   // interrupt request and code
   logic [15:1] req;
   logic any_req;
   logic [3:0] code;
   always_comb begin
      req = ~int_level_n & mask_q;
      req[3] = timer_en ? (clk_int_q & mask_q[3]) : req[3];
   end

   iopit_prio_enc u_enc (
      .active(req),
      .any(any_req),
      .code(code)
   );

   iopit_pkg::iopit_code_state_t cst_q, cst_d;
   logic irq_n_q, irq_n_d;
   logic [3:0] code_q, code_d;
   always_comb begin
      cst_d = iopit_pkg::IOPIT_CODE_RUN;
      irq_n_d = !any_req;
      code_d = code;
   end
   always_ff @(posedge clk) begin
      if (rst_any) begin
         cst_q <= iopit_pkg::IOPIT_CODE_HOLD_RESET;
         irq_n_q <= 1'b1;
         code_q <= `IOPIT_CODE_RESET;
      end else begin
         cst_q <= cst_d;
         irq_n_q <= irq_n_d;
         code_q <= code_d;
      end
   end
   assign interrupt_request_n = irq_n_q;
   assign interrupt_code_lines = code_q;
   assign port_out = pout_q;
   assign port_oe = poe_q;

   // read path
   logic rd_d, rd_q;
   always_comb begin
      rd_d = 1'b0;
      if (bus_rd) begin
         if (is_port(bus_addr)) begin
            rd_d = port_in[idx];
         end else if (bus_addr == `IOPIT_ADDR_CTRL) begin
            rd_d = mode_q;
         end else if (!mode_q) begin
            rd_d = int_level_n[idx];
         end else if (bus_addr == `IOPIT_ADDR_TOP_INT) begin
            rd_d = !irq_n_q;
         end else begin
            rd_d = cap_q[idx - 4'(1)];
         end
      end
   end
   always_ff @(posedge clk) begin
      if (rst_any) begin
         rd_q <= 1'b0;
      end else begin
         rd_q <= rd_d;
      end
   end
   assign bus_rdata = rd_q;

   chk_port_write_oe: assert property (@(posedge clk) disable iff (rst_any)
      wr_port |=> port_oe[$past(idx)] && port_out[$past(idx)] == $past(bus_wdata))
      else $error("port write did not drive pin");
   chk_soft_port_reset: assert property (@(posedge clk) disable iff (rst_any)
      wr_low && mode_q && bus_addr == `IOPIT_ADDR_TOP_INT && bus_wdata && !wr_port
      |=> port_oe == '0)
      else $error("software port reset missed");
   chk_mask3_clear: assert property (@(posedge clk) disable iff (rst_any)
      clear_int && !(timer_en && tick) |=> !clk_int_q)
      else $error("clock interrupt not cleared");
   chk_zero_disable: assert property (@(posedge clk) disable iff (rst_any)
      !timer_en |=> !clk_int_q)
      else $error("disabled timer holds interrupt");
   chk_capture_mode: assert property (@(posedge clk) disable iff (rst_any)
      wr_low && bus_addr == `IOPIT_ADDR_CTRL && bus_wdata |=> cap_q == $past(cnt_q))
      else $error("capture missed");
   chk_mode_read: assert property (@(posedge clk) disable iff (rst_any)
      bus_rd && bus_addr == `IOPIT_ADDR_CTRL |=> bus_rdata == $past(mode_q))
      else $error("mode read wrong");
   chk_restart_load: assert property (@(posedge clk) disable iff (rst_any)
      restart |=> cnt_q == start_q)
      else $error("restart did not load");
   // one prescaled step of an enabled timer
   sequence s_tick_step;
      timer_en && tick && !restart;
   endsequence
   sequence s_expire;
      s_tick_step ##0 cnt_q <= TW'(1);
   endsequence
   sequence s_count_down;
      s_tick_step ##0 cnt_q > TW'(1);
   endsequence
   chk_expiry_reload: assert property (@(posedge clk) disable iff (rst_any)
      s_expire |=> clk_int_q && cnt_q == $past(start_q))
      else $error("expiry did not reload and flag");
   chk_count_step: assert property (@(posedge clk) disable iff (rst_any)
      s_count_down |=> cnt_q == $past(cnt_q) - TW'(1))
      else $error("counter step wrong");
   chk_oe_sticky: assert property (@(posedge clk) disable iff (rst_any)
      !soft_rst |=> (port_oe & $past(port_oe)) == $past(port_oe))
      else $error("output direction dropped");
   chk_request_raise: assert property (@(posedge clk) disable iff (rst_any)
      (req != '0) |=> !interrupt_request_n)
      else $error("request not raised");
   chk_read_capture: assert property (@(posedge clk) disable iff (rst_any)
      bus_rd && mode_q && !is_port(bus_addr) && idx != 4'h0 && idx != 4'hf
      |=> bus_rdata == $past(cap_q[idx - 4'(1)]))
      else $error("capture read wrong");
   chk_reset_code: assert property (@(posedge clk)
      rst_any |=> interrupt_code_lines == `IOPIT_CODE_RESET && interrupt_request_n)
      else $error("reset code wrong");
endmodule // iopit_top
`default_nettype wire

/* File: testbench/iopit_host.sv */
// host model driving the bit-addressed register port
`timescale 1ns/1ps
`default_nettype none
module iopit_host (
   input wire logic clk,
   output logic [4:0] bus_addr,
   output logic bus_wdata,
   output logic bus_wr,
   output logic bus_rd,
   input wire logic bus_rdata
);
   initial begin
      bus_addr = 5'h00;
      bus_wdata = 1'b0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
   end
   task automatic wr(input logic [4:0] a, input logic b);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= b;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic b);
      @(posedge clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1;
      b = bus_rdata;
   endtask
endmodule // iopit_host
`default_nettype wire

/* File: testbench/tb_iopit_top.sv */
// self-checking bench for the io port and interval timer
`timescale 1ns/1ps
`default_nettype none
module tb_iopit_top;
   localparam int PS = 4;
   localparam int SV = 10;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic power_up_reset_n = 1'b0;
   logic [4:0] bus_addr;
   logic bus_wdata, bus_wr, bus_rd, bus_rdata;
   logic [6:1] int_pin_n = 6'h3f;
   logic [15:0] port_in = 16'h0000;
   logic [15:0] port_out, port_oe, m_out, m_oe, pin, d;
   logic interrupt_request_n, m_mode, r;
   logic [3:0] interrupt_code_lines;
   logic [13:0] v;
   int err_total = 0;
   int compares = 0;
   int cyc = 0;
   int t0;
   always #2.5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   iopit_host u_iopit_host (.clk, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata);
   iopit_top #(.PRESCALE(PS)) u_iopit_top (.clk, .sys_rst, .power_up_reset_n, .bus_addr,
      .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .int_pin_n, .port_in, .port_out, .port_oe,
      .interrupt_request_n, .interrupt_code_lines);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // write through the host, mirrored in the model
   task automatic put(input logic [4:0] a, input logic b);
      u_iopit_host.wr(a, b);
      #1;
      if (a == 5'h00)
         m_mode = b;
      if (a[4]) begin
         m_oe[a[3:0]] = 1'b1;
         m_out[a[3:0]] = b;
      end
      if (m_mode && b && a == 5'h0f)
         m_oe = 16'h0000;
   endtask
   task automatic get(input logic [4:0] a, input logic e);
      u_iopit_host.rd(a, r);
      chk(32'(r), 32'(e));
   endtask
   task automatic wreq(input logic lv, input int lim);
      for (int n = 0; interrupt_request_n !== lv; n++) begin
         if (n == lim) begin
            err_total++;
            wrap_up();
         end
         tick(1);
      end
   endtask
   initial begin
      #200000;
      err_total++;
      wrap_up();
   end
   initial begin
      void'($urandom(3225));
      m_out = 16'h0000;
      m_oe = 16'h0000;
      m_mode = 1'b0;
      pin = 16'($urandom);
      d = 16'($urandom);
      tick(2);
      chk(32'({interrupt_request_n, interrupt_code_lines, port_oe}), 32'h100000);
      @(posedge clk);
      sys_rst <= 1'b0;
      power_up_reset_n <= 1'b1;
      port_in <= pin;
      for (int i = 0; i < 16; i++)
         put(5'(16 + i), d[i]);
      chk({port_oe, port_out}, {m_oe, m_out});
      for (int i = 0; i < 16; i++)
         get(5'(16 + i), pin[i]);
      chk(32'(port_out), 32'(m_out));
      put(5'h00, 1'b1);
      put(5'h0f, 1'b1);
      chk(32'(port_oe), 32'(m_oe));
      put(5'h00, 1'b0);
      $display("ports done");
      @(posedge clk);
      int_pin_n <= 6'($urandom);
      pin = 16'($urandom);
      port_in <= pin;
      tick(3);
      get(5'h00, 1'b0);
      for (int a = 1; a < 16; a++)
         get(5'(a), a < 7 ? int_pin_n[a] : pin[22 - a]);
      $display("reads done");
      @(posedge clk);
      int_pin_n <= 6'h2b;
      port_in <= 16'hffff;
      put(5'h05, 1'b1);
      wreq(1'b0, 8);
      chk(32'(interrupt_code_lines), 32'h5);
      put(5'h05, 1'b0);
      put(5'h03, 1'b1);
      tick(2);
      chk(32'({interrupt_request_n, interrupt_code_lines}), 32'h03);
      put(5'h00, 1'b1);
      for (int b = 1; b < 15; b++)
         put(5'(b), SV[b - 1]);
      put(5'h00, 1'b0);
      tick(2);
      chk(32'(interrupt_request_n), 32'h1);
      wreq(1'b0, SV * PS + 8);
      t0 = cyc;
      chk(32'(interrupt_code_lines), 32'h3);
      tick(8);
      chk(32'(interrupt_request_n), 32'h0);
      put(5'h03, 1'b1);
      wreq(1'b1, 4);
      wreq(1'b0, SV * PS);
      chk(cyc - t0, SV * PS);
      put(5'h00, 1'b1);
      get(5'h00, 1'b1);
      get(5'h0f, 1'b1);
      for (int b = 1; b < 15; b++) begin
         u_iopit_host.rd(5'(b), r);
         v[b - 1] = r;
      end
      chk(32'(v <= SV), 32'h1);
      put(5'h03, SV[2]);
      tick(2);
      get(5'h0f, 1'b0);
      for (int b = 1; b < 15; b++)
         put(5'(b), 1'b0);
      put(5'h00, 1'b0);
      @(posedge clk);
      int_pin_n <= 6'h3f;
      tick(2 * SV * PS);
      chk(32'(interrupt_request_n), 32'h1);
      @(posedge clk);
      int_pin_n <= 6'h3b;
      wreq(1'b0, 8);
      chk(32'(interrupt_code_lines), 32'h3);
      $display("timer done");
      wrap_up();
   end
endmodule // tb_iopit_top
`default_nettype wire
